// *** rtl/shb_hub.sv ***
// sensor hub end: command words, dummy slot reservation, slot map
// and an eight-entry error history with a nonvolatile write port.
// flags a master that drops the trigger before done; the nv store is outside.
`timescale 1ns/1ps
`default_nettype none

module shb_hub (
  input  wire logic          sys_clk,        // 125 MHz clock
  input  wire logic          rst_n,          // async reset, active low
  shb_link_if.hub            link,           // master side
  input  wire logic [4:0]    direct_count,   // amplifiers on the hub itself
  input  wire logic [31:0]   exp_count,      // 4 bits per expansion unit
  input  wire logic          ev_comm,        // amplifier link fault pulse
  input  wire logic          ev_setval,      // bad value or tuning fail pulse
  input  wire logic          ev_status,      // amplifier not ready pulse
  input  wire logic          ev_cmd,         // amplifier refused command pulse
  output logic [15:0]        dummy_mask,     // active dummy slots
  output logic [127:0]       slot_map,       // per slot {group, position}
  output logic [15:0]        slot_used,      // slot holds an amplifier
  output logic               nv_wr,          // nv history entry write
  output logic [2:0]         nv_addr,        // nv entry index
  output logic [7:0]         nv_data,        // nv entry code
  output logic               nv_clr          // nv history erase pulse
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} shb_state_t;

  // -----------------------------------------------------------------
  // command words
  // -----------------------------------------------------------------
  logic [15:0] cmd_unit_q, cmd_chan_q, cmd_type_q, cmd_arg_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_unit_q <= shb_pkg::REG_RESET_VAL;
      cmd_chan_q <= shb_pkg::REG_RESET_VAL;
      cmd_type_q <= shb_pkg::REG_RESET_VAL;
      cmd_arg_q  <= shb_pkg::REG_RESET_VAL;
    end else if (link.wr_en) begin
      unique case (link.wr_addr)
        shb_pkg::REG_CMD_UNIT:    cmd_unit_q <= link.wr_data;
        shb_pkg::REG_CMD_CHANNEL: cmd_chan_q <= link.wr_data;
        shb_pkg::REG_CMD_TYPE:    cmd_type_q <= link.wr_data;
        shb_pkg::REG_CMD_ARG1:    cmd_arg_q  <= link.wr_data;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  wire is_dummy  = (cmd_type_q == shb_pkg::CMD_DUMMY_SET);
  wire is_hread  = (cmd_type_q == shb_pkg::CMD_HIST_READ);
  wire is_hclr   = (cmd_type_q == shb_pkg::CMD_HIST_CLR);
  wire chan_bad  = (cmd_chan_q > shb_pkg::CHAN_MAX);
  wire unit_bad  = (cmd_unit_q > 16'(shb_pkg::NUM_SLOTS));
  wire idx_bad   = (cmd_arg_q > 16'(shb_pkg::HIST_DEPTH - 1));
  wire known     = is_dummy | is_hread | is_hclr;

  logic [7:0] exec_err;
  always_comb begin
    exec_err = shb_pkg::ERR_NONE;
    if (!known || chan_bad || unit_bad) begin
      exec_err = shb_pkg::ERR_CMD;
    end else if (is_hread && idx_bad) begin
      exec_err = shb_pkg::ERR_SETVAL;
    end
  end

  // -----------------------------------------------------------------
  // command sequencer
  // -----------------------------------------------------------------
  shb_state_t  state_q;
  logic [7:0]  cnt_q;
  logic        done_q;
  logic [7:0]  err_q;
  logic [15:0] resp_q;
  logic [15:0] dummy_q;

  wire exec_now  = (state_q == ST_EXEC) && link.command_trigger && (cnt_q == 8'h00);
  wire trig_lost = (state_q == ST_EXEC) && !link.command_trigger;
  wire ok_now    = exec_now && (exec_err == shb_pkg::ERR_NONE);
  wire do_clr    = ok_now && is_hclr;

  logic [7:0] hist_q [shb_pkg::HIST_DEPTH];
  logic [2:0] wp_q;
  wire  [2:0] rd_idx = 3'(wp_q - 3'h1 - cmd_arg_q[2:0]);   // 0 = newest

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 8'h00;
      done_q  <= 1'b0;
      err_q   <= shb_pkg::ERR_NONE;
      resp_q  <= 16'h0000;
      dummy_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          done_q <= 1'b0;
          if (link.command_trigger) begin
            state_q <= ST_EXEC;
            cnt_q   <= 8'(shb_pkg::CMD_PROC_CYC - 1);
          end
        end
        ST_EXEC: begin
          if (trig_lost) begin
            err_q   <= shb_pkg::ERR_TRIG;
            state_q <= ST_IDLE;
          end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            err_q   <= exec_err;
            done_q  <= 1'b1;
            state_q <= ST_DONE;
            resp_q  <= is_hread ? {8'h00, hist_q[rd_idx]} : 16'h0000;
            if (ok_now && is_dummy) begin
              dummy_q <= cmd_arg_q;
            end
          end
        end
        ST_DONE: begin
          if (!link.command_trigger) begin
            done_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cmd_done  = done_q;
  assign link.cmd_err   = err_q;
  assign link.resp_data = resp_q;
  assign dummy_mask     = dummy_q;

  // -----------------------------------------------------------------
  // error capture and history
  // -----------------------------------------------------------------
  // one entry is logged per cycle, so a burst waits in pending bits
  logic [4:0] pend_q;
  wire  [4:0] new_err = {trig_lost, exec_now && exec_err == shb_pkg::ERR_CMD,
                         ev_status,
                         ev_setval | (exec_now && exec_err == shb_pkg::ERR_SETVAL),
                         ev_comm};
  logic [4:0] log_mask;
  logic [7:0] log_code;

  always_comb begin
    log_mask = 5'h00;
    log_code = shb_pkg::ERR_NONE;
    for (int i = 0; i < shb_pkg::ERR_KINDS; i++) begin
      if (pend_q[i]) begin
        log_mask = 5'(1 << i);
        log_code = 8'(1 << i);
      end
    end
  end

  // ev_cmd is an amplifier-side refusal and shares the command slot
  wire [4:0] set_err = new_err | {1'b0, ev_cmd, 3'b000};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 5'h00;
      wp_q   <= 3'h0;
      nv_wr  <= 1'b0;
      nv_addr <= 3'h0;
      nv_data <= shb_pkg::ERR_NONE;
      nv_clr <= 1'b0;
      for (int i = 0; i < shb_pkg::HIST_DEPTH; i++) begin
        hist_q[i] <= shb_pkg::ERR_NONE;
      end
    end else begin
      pend_q <= (pend_q & ~log_mask) | set_err;            // set wins over clear
      nv_clr <= do_clr;
      nv_wr  <= (log_mask != 5'h00);
      if (do_clr) begin
        for (int i = 0; i < shb_pkg::HIST_DEPTH; i++) begin
          hist_q[i] <= shb_pkg::ERR_NONE;
        end
        wp_q <= 3'h0;
      end
      if (log_mask != 5'h00) begin
        hist_q[do_clr ? 3'h0 : wp_q] <= log_code;
        wp_q    <= do_clr ? 3'h1 : wp_q + 3'h1;
        nv_addr <= do_clr ? 3'h0 : wp_q;
        nv_data <= log_code;
      end
    end
  end

  // -----------------------------------------------------------------
  // slot map
  // -----------------------------------------------------------------
  logic [7:0]  amp_list [shb_pkg::NUM_SLOTS];
  logic [4:0]  amp_total;
  logic [4:0]  grp_cnt;
  logic [127:0] map_d;
  logic [15:0]  used_d;
  logic [4:0]   nxt;

  always_comb begin
    amp_total = 5'h00;
    for (int k = 0; k < shb_pkg::NUM_SLOTS; k++) begin
      amp_list[k] = 8'h00;
    end
    // group 0 is the hub itself, groups 1..8 the expansions in order
    for (int g = 0; g <= shb_pkg::NUM_EXP; g++) begin
      if (g == 0) begin
        grp_cnt = direct_count;
      end else if (exp_count[4*(g-1) +: 4] > 4'(shb_pkg::EXP_AMP_MAX)) begin
        grp_cnt = 5'(shb_pkg::EXP_AMP_MAX);
      end else begin
        grp_cnt = {1'b0, exp_count[4*(g-1) +: 4]};
      end
      for (int p = 0; p < shb_pkg::NUM_SLOTS; p++) begin
        if (5'(p) < grp_cnt && amp_total < 5'(shb_pkg::NUM_SLOTS)) begin
          amp_list[amp_total[3:0]] = {4'(g), 4'(p)};
          amp_total = amp_total + 5'h01;
        end
      end
    end
    nxt    = 5'h00;
    map_d  = 128'h0;
    used_d = 16'h0000;
    for (int s = 0; s < shb_pkg::NUM_SLOTS; s++) begin
      if (!dummy_q[s] && nxt < amp_total) begin
        map_d[8*s +: 8] = amp_list[nxt[3:0]];
        used_d[s]       = 1'b1;
        nxt             = nxt + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_map  <= 128'h0;
      slot_used <= 16'h0000;
    end else begin
      slot_map  <= map_d;
      slot_used <= used_d;
    end
  end

endmodule
`default_nettype wire

// *** rtl/shb_pkg.sv ***
// shared constants of the sensor hub command logic: register offsets,
// command codes, error codes, sizes and timing.
// assumes one 125 MHz clock shared by both ends.
package shb_pkg;

  // -----------------------------------------------------------------
  // command word offsets (16-bit words)
  // -----------------------------------------------------------------
  localparam logic [1:0] REG_CMD_UNIT    = 2'h0;
  localparam logic [1:0] REG_CMD_CHANNEL = 2'h1;
  localparam logic [1:0] REG_CMD_TYPE    = 2'h2;
  localparam logic [1:0] REG_CMD_ARG1    = 2'h3;
  localparam logic [15:0] REG_RESET_VAL  = 16'h0000;

  // -----------------------------------------------------------------
  // command codes
  // -----------------------------------------------------------------
  localparam logic [15:0] CMD_DUMMY_SET = 16'h0015;
  localparam logic [15:0] CMD_HIST_READ = 16'h0016;
  localparam logic [15:0] CMD_HIST_CLR  = 16'h0017;
  localparam logic [15:0] CHAN_MAX      = 16'h0001;

  // -----------------------------------------------------------------
  // error codes, value is also priority
  // -----------------------------------------------------------------
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam logic [7:0] ERR_COMM   = 8'h01;
  localparam logic [7:0] ERR_SETVAL = 8'h02;
  localparam logic [7:0] ERR_STATUS = 8'h04;
  localparam logic [7:0] ERR_CMD    = 8'h08;
  localparam logic [7:0] ERR_TRIG   = 8'h10;
  localparam int         ERR_KINDS  = 5;

  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int NUM_SLOTS    = 16;
  localparam int NUM_EXP      = 8;
  localparam int EXP_AMP_MAX  = 10;
  localparam int HIST_DEPTH   = 8;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CMD_PROC_NS   = 80;
  localparam int CMD_PROC_CYC  = (CMD_PROC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// *** rtl/shb_link_if.sv ***
// link between fieldbus master end and sensor hub end.
// assumes both ends share sys_clk; the bench joins the two modules.
`timescale 1ns/1ps
`default_nettype none
interface shb_link_if;
  logic        wr_en;            // master writes one command word
  logic [1:0]  wr_addr;          // command word offset
  logic [15:0] wr_data;          // command word value
  logic        command_trigger;  // held high while a command runs
  logic        cmd_done;         // device finished, held until trigger drops
  logic [7:0]  cmd_err;          // error code of finished command
  logic [15:0] resp_data;        // response word

  modport hub (
    input  wr_en, wr_addr, wr_data, command_trigger,
    output cmd_done, cmd_err, resp_data
  );
  modport master (
    output wr_en, wr_addr, wr_data, command_trigger,
    input  cmd_done, cmd_err, resp_data
  );
endinterface
`default_nettype wire

// *** rtl/shb_master.sv ***
// fieldbus master end: writes the four command words, then raises the
// trigger and holds it until the hub reports done.
// assumes the hub end on the same clock.
`timescale 1ns/1ps
`default_nettype none
module shb_master (
  input  wire logic        sys_clk,    // 125 MHz clock
  input  wire logic        rst_n,      // async reset, active low
  shb_link_if.master       link,       // hub side
  input  wire logic        req,        // start a command, pulse
  input  wire logic [15:0] req_unit,   // target unit number
  input  wire logic [15:0] req_chan,   // sensor channel
  input  wire logic [15:0] req_type,   // command type
  input  wire logic [15:0] req_arg,    // command argument one
  output logic             busy,       // command in progress
  output logic             fin,        // command finished, pulse
  output logic [7:0]       fin_err,    // error code of finished command
  output logic [15:0]      fin_data    // response word
);

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_TRIG, ST_DROP} shb_mstate_t;

  shb_mstate_t state_q;
  logic [1:0]  widx_q;
  logic [15:0] w_q [4];
  logic        wr_q;
  logic [1:0]  addr_q;
  logic [15:0] data_q;
  logic        trig_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      widx_q   <= 2'h0;
      wr_q     <= 1'b0;
      addr_q   <= 2'h0;
      data_q   <= 16'h0000;
      trig_q   <= 1'b0;
      busy     <= 1'b0;
      fin      <= 1'b0;
      fin_err  <= 8'h00;
      fin_data <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        w_q[i] <= 16'h0000;
      end
    end else begin
      fin  <= 1'b0;
      wr_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (req) begin
            w_q[shb_pkg::REG_CMD_UNIT]    <= req_unit;
            w_q[shb_pkg::REG_CMD_CHANNEL] <= req_chan;
            w_q[shb_pkg::REG_CMD_TYPE]    <= req_type;
            w_q[shb_pkg::REG_CMD_ARG1]    <= req_arg;
            widx_q  <= 2'h0;
            busy    <= 1'b1;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          wr_q   <= 1'b1;
          addr_q <= widx_q;
          data_q <= w_q[widx_q];
          widx_q <= widx_q + 2'h1;
          if (widx_q == 2'h3) begin
            state_q <= ST_TRIG;
          end
        end
        ST_TRIG: begin
          trig_q <= 1'b1;
          if (trig_q && link.cmd_done) begin
            trig_q   <= 1'b0;
            fin_err  <= link.cmd_err;
            fin_data <= link.resp_data;
            state_q  <= ST_DROP;
          end
        end
        ST_DROP: begin
          if (!link.cmd_done) begin
            busy    <= 1'b0;
            fin     <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign link.wr_en           = wr_q;
  assign link.wr_addr         = addr_q;
  assign link.wr_data         = data_q;
  assign link.command_trigger = trig_q;

endmodule
`default_nettype wire

// *** sim/shb_link_monitor.sv ***
// checker of the command link between master end and hub end.
// assumes the bench feeds it one link at a time, on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module shb_link_monitor (
  input  wire logic        sys_clk,          // 125 MHz clock
  input  wire logic        rst_n,            // async reset, active low
  input  wire logic        wr_en,            // word write strobe
  input  wire logic [1:0]  wr_addr,          // word offset
  input  wire logic [15:0] wr_data,          // word value
  input  wire logic        command_trigger,  // command trigger level
  input  wire logic        cmd_done,         // command finished
  input  wire logic [7:0]  cmd_err,          // error code
  input  wire logic [15:0] resp_data         // response word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_cmd_run;
    $rose(command_trigger) ##1 command_trigger [*8];
  endsequence
  sequence s_words;
    wr_en && wr_addr == shb_pkg::REG_CMD_CHANNEL ##1 wr_en && wr_addr == shb_pkg::REG_CMD_TYPE
      ##1 wr_en && wr_addr == shb_pkg::REG_CMD_ARG1;
  endsequence
  sequence s_early_drop;
    $fell(command_trigger) && !cmd_done && !$past(cmd_done);
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_no_early_done: assert property ($rose(command_trigger) |-> !cmd_done [*8])
    else $error("done came too early");
  a_done_latency: assert property (s_cmd_run |-> ##[3:4] cmd_done)
    else $error("done missing after processing time");
  a_done_holds: assert property (cmd_done && command_trigger |=> cmd_done)
    else $error("done dropped while trigger high");
  a_done_release: assert property (cmd_done && !command_trigger |=> !cmd_done)
    else $error("done kept after trigger low");
  a_drop_err_code: assert property (s_early_drop |-> ##[0:2] cmd_err == shb_pkg::ERR_TRIG)
    else $error("early drop not flagged");
  a_drop_no_done: assert property (s_early_drop |-> !cmd_done [*4])
    else $error("done after early drop");
  a_word_order: assert property (wr_en && wr_addr == shb_pkg::REG_CMD_UNIT |=> s_words)
    else $error("command words out of order");
  a_trig_after_args: assert property (wr_en && wr_addr == shb_pkg::REG_CMD_ARG1
    |-> ##[0:2] command_trigger)
    else $error("trigger missing after words");
  a_err_steady: assert property (command_trigger && $past(command_trigger) && !cmd_done
    |-> $stable(cmd_err))
    else $error("error code moved mid command");
  a_resp_steady: assert property (command_trigger && $past(command_trigger) && !cmd_done
    |-> $stable(resp_data))
    else $error("response moved mid command");
  a_data_quiet: assert property (!wr_en |-> $stable(wr_data))
    else $error("word data moved without a write");
endmodule
`default_nettype wire

// *** sim/sensor_hub_dummy_slot_and_error_log_tb.sv ***
// testbench: master and hub joined on one link, plus a second hub
// driven directly to drop the trigger early.
// assumes the design files of rtl are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sensor_hub_dummy_slot_and_error_log_tb;
  typedef struct packed {
    logic [15:0] unit;
    logic [15:0] chan;
    logic [15:0] typ;
    logic [15:0] arg;
    logic [7:0]  err;
    logic [15:0] mask;
  } shb_row_t;

  logic         sys_clk, rst_n, req, busy, fin, clr_seen, mon_b;
  logic [15:0]  req_unit, req_chan, req_type, req_arg, fin_data;
  logic [7:0]   fin_err, nv_data;
  logic [4:0]   direct_count;
  logic [31:0]  exp_count;
  logic         ev_comm, ev_setval, ev_status, ev_cmd, nv_wr, nv_clr;
  logic [15:0]  dummy_mask, slot_used, dummy_mask_b;
  logic [127:0] slot_map;
  logic [2:0]   nv_addr;
  logic [10:0]  nv_q [$];
  int           errors, samples_checked, cycles;
  shb_row_t     rows [0:7] = '{
    {16'h0001, 16'h0000, 16'h0015, 16'h0038, 8'h00, 16'h0038},
    {16'h0001, 16'h0000, 16'h0015, 16'h0030, 8'h00, 16'h0030},
    {16'h0001, 16'h0000, 16'h0015, 16'hFFFF, 8'h00, 16'hFFFF},
    {16'h0001, 16'h0000, 16'h0015, 16'h0000, 8'h00, 16'h0000},
    {16'h0001, 16'h0000, 16'h0099, 16'h0005, 8'h08, 16'h0000},
    {16'h0001, 16'h0002, 16'h0015, 16'h0005, 8'h08, 16'h0000},
    {16'h0011, 16'h0000, 16'h0015, 16'h0005, 8'h08, 16'h0000},
    {16'h0001, 16'h0000, 16'h0016, 16'h0008, 8'h02, 16'h0000}
  };

  shb_link_if link_a ();
  shb_link_if link_b ();

  shb_master i_shb_master (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_a), .req(req),
    .req_unit(req_unit), .req_chan(req_chan), .req_type(req_type), .req_arg(req_arg),
    .busy(busy), .fin(fin), .fin_err(fin_err), .fin_data(fin_data));
  shb_hub i_shb_hub (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_a),
    .direct_count(direct_count), .exp_count(exp_count), .ev_comm(ev_comm),
    .ev_setval(ev_setval), .ev_status(ev_status), .ev_cmd(ev_cmd), .dummy_mask(dummy_mask),
    .slot_map(slot_map), .slot_used(slot_used), .nv_wr(nv_wr), .nv_addr(nv_addr),
    .nv_data(nv_data), .nv_clr(nv_clr));
  // second hub sees a master that breaks the trigger protocol
  shb_hub i_shb_hub_b (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_b),
    .direct_count(direct_count), .exp_count(exp_count), .ev_comm(ev_comm),
    .ev_setval(ev_setval), .ev_status(ev_status), .ev_cmd(ev_cmd),
    .dummy_mask(dummy_mask_b), .slot_map(), .slot_used(), .nv_wr(), .nv_addr(),
    .nv_data(), .nv_clr());
  // monitor follows link_a, then link_b for the early-drop case
  wire logic        mon_wr_en = mon_b ? link_b.wr_en : link_a.wr_en;
  wire logic [1:0]  mon_addr  = mon_b ? link_b.wr_addr : link_a.wr_addr;
  wire logic [15:0] mon_wdata = mon_b ? link_b.wr_data : link_a.wr_data;
  wire logic        mon_trig  = mon_b ? link_b.command_trigger : link_a.command_trigger;
  wire logic        mon_done  = mon_b ? link_b.cmd_done : link_a.cmd_done;
  wire logic [7:0]  mon_err   = mon_b ? link_b.cmd_err : link_a.cmd_err;
  wire logic [15:0] mon_resp  = mon_b ? link_b.resp_data : link_a.resp_data;
  shb_link_monitor i_shb_link_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
    .wr_en(mon_wr_en), .wr_addr(mon_addr), .wr_data(mon_wdata),
    .command_trigger(mon_trig), .cmd_done(mon_done),
    .cmd_err(mon_err), .resp_data(mon_resp));

  // ----------------------------------------
  // clock, timeout, history capture
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  always @(posedge sys_clk) begin
    if (nv_wr === 1'b1) nv_q.push_back({nv_addr, nv_data});
    if (nv_clr === 1'b1) clr_seen = 1'b1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic run_cmd(input logic [15:0] u, c, t, a);
    int n;
    @(negedge sys_clk);
    req = 1'b1;
    {req_unit, req_chan, req_type, req_arg} = {u, c, t, a};
    @(negedge sys_clk);
    req = 1'b0;
    chk("busy", busy, 1'b1);
    n = 0;
    while (fin !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("fin", fin, 1'b1);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {errors, samples_checked, cycles} = '0;
    {rst_n, req, clr_seen, mon_b, ev_comm, ev_setval, ev_status, ev_cmd} = '0;
    {req_unit, req_chan, req_type, req_arg} = '0;
    direct_count = 5'h02;
    exp_count = 32'h0000_0102;
    {link_b.wr_en, link_b.wr_addr, link_b.wr_data, link_b.command_trigger} = '0;
    repeat (8) @(negedge sys_clk);
    chk("reset mask", dummy_mask, 16'h0000);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run_cmd(rows[i].unit, rows[i].chan, rows[i].typ, rows[i].arg);
      chk("row err", fin_err, rows[i].err);
      chk("row mask", dummy_mask, rows[i].mask);
    end
    // slot 2 held by a dummy, hub amps then expansion 1 then 3
    run_cmd(16'h0001, 16'h0000, 16'h0015, 16'h0004);
    repeat (3) @(negedge sys_clk);
    chk("slot map", slot_map, 128'h3011_1000_0100);
    chk("slot used", slot_used, 16'h003B);
    rst_n = 1'b0;
    #1;
    chk("mid reset mask", dummy_mask, 16'h0000);
    chk("mid reset busy", busy, 1'b0);
    @(negedge sys_clk);
    rst_n = 1'b1;
    // expansion 1 capped at ten, whole system capped at sixteen
    direct_count = 5'h02;
    exp_count = 32'h0000_008F;
    repeat (3) @(negedge sys_clk);
    chk("cap used", slot_used, 16'hFFFF);
    chk("cap tail", slot_map[127:96], 32'h2322_2120);
    run_cmd(16'h0001, 16'h0000, 16'h0017, 16'h0000);
    chk("clear pulse", clr_seen, 1'b1);
    nv_q.delete();
    @(negedge sys_clk);
    {ev_comm, ev_status, ev_cmd} = 3'h7;
    @(negedge sys_clk);
    {ev_comm, ev_status, ev_cmd} = 3'h0;
    repeat (6) begin
      @(negedge sys_clk);
      ev_setval = 1'b1;
      @(negedge sys_clk);
      ev_setval = 1'b0;
    end
    repeat (10) @(negedge sys_clk);
    chk("log count", nv_q.size(), 9);
    // a 02h that arrives while 01h still waits is logged first
    for (int k = 0; k < 9 && k < nv_q.size(); k++) begin
      chk("log entry", nv_q[k], {3'(k), k == 0 ? 8'h08 : k == 1 ? 8'h04
        : k == 3 ? 8'h01 : 8'h02});
    end
    run_cmd(16'h0001, 16'h0000, 16'h0016, 16'h0007);
    chk("oldest", fin_data[7:0], 8'h04);
    run_cmd(16'h0001, 16'h0000, 16'h0016, 16'h0000);
    chk("newest", fin_data[7:0], 8'h02);
    run_cmd(16'h0001, 16'h0000, 16'h0017, 16'h0000);
    run_cmd(16'h0001, 16'h0000, 16'h0016, 16'h0000);
    chk("empty", fin_data[7:0], 8'h00);
    // second link: trigger released before the hub is done
    mon_b = 1'b1;
    @(negedge sys_clk);
    {link_b.wr_en, link_b.wr_addr, link_b.wr_data} = {1'b1, 2'h2, 16'h0015};
    @(negedge sys_clk);
    {link_b.wr_addr, link_b.wr_data} = {2'h3, 16'h00FF};
    @(negedge sys_clk);
    {link_b.wr_en, link_b.command_trigger} = 2'b01;
    repeat (4) @(negedge sys_clk);
    link_b.command_trigger = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("drop err", link_b.cmd_err, 8'h10);
    chk("drop done", link_b.cmd_done, 1'b0);
    chk("drop mask", dummy_mask_b, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
